//--- rtl/rtc_status_ctrl.sv
// rtd channel status, calibration flags, timestamps and process alarms
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rtc_status_ctrl
   import rtc_pkg::*;
#(
   parameter int SAMPLE_HZ = RTC_RATE_HZ,
   parameter int MS_CYC    = RTC_MS_CYC
)(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire rtc_sample_s           sample_in,
   input  wire rtc_cal_s              cal_in,
   input  wire logic [63:0]           sys_time,
   input  wire logic [6:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [6:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic [31:0]                alarm_flags,
   output logic [31:0]                cal_flags
);
   // software registers
   logic [31:0]        enable_reg;
   logic [31:0]        release_reg;
   logic [31:0]        release_prev_reg;
   logic signed [31:0] lim_reg [4];
   logic [31:0]        dband_reg;
   logic [3:0]         latch_reg;
   logic [2:0]         chsel_reg;
   // channel state
   logic signed [31:0] data_reg [RTC_NCH];
   logic signed [31:0] rate_reg [RTC_NCH];
   logic [RTC_NCH-1:0] good_high_ref_flag;
   logic [RTC_NCH-1:0] bad_high_ref_flag;
   logic [RTC_NCH-1:0] cal_done_ok_flag;
   logic [RTC_NCH-1:0] cal_fault_flag;
   logic [9:0]         ok_cnt_reg [RTC_NCH];
   rtc_cal_e           cal_st_reg [RTC_NCH];
   logic [31:0]        alarm_reg;
   logic [63:0]        stamp_reg;
   logic [RTC_NCH-1:0] seen_reg;
   logic [15:0]        wrapping_ms_stamp;
   logic [31:0]        ms_cnt_reg;
   logic               upd_pulse;
   logic [31:0]        release_edge;

   // write channel: take address and data in either order
   logic       aw_have, w_have;
   logic [6:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic       do_write;
   assign s_axi_awready = !aw_have && !s_axi_bvalid;
   assign s_axi_wready  = !w_have && !s_axi_bvalid;
   assign do_write      = aw_have && w_have && !s_axi_bvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have      <= 1'b0;
         w_have       <= 1'b0;
         aw_addr      <= 7'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RTC_RESP_OK;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[6:2] <= RTC_OFS_LATCH[6:2] && aw_addr[6:2] != 5'h00)
                            || aw_addr[6:2] == RTC_OFS_ENABLE[6:2]
                            || aw_addr[6:2] == RTC_OFS_CHSEL[6:2] ? RTC_RESP_OK : RTC_RESP_SLV;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (st[b])
            r[8*b +: 8] = nw[8*b +: 8];
      return r;
   endfunction

   // control registers written by software; release bits come from the controller here
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         enable_reg  <= 32'h0000_0000;
         release_reg <= 32'h0000_0000;
         dband_reg   <= 32'h0000_0000;
         latch_reg   <= 4'h0;
         chsel_reg   <= 3'h0;
         for (int i = 0; i < 4; i++)
            lim_reg[i] <= 32'sh0000_0000;
      end
      else if (do_write)
      begin
         case (aw_addr[6:2])
            RTC_OFS_ENABLE[6:2]:  enable_reg  <= merge(enable_reg, w_data, w_strb);
            RTC_OFS_RELEASE[6:2]: release_reg <= merge(release_reg, w_data, w_strb);
            RTC_OFS_LIMLL[6:2]:   lim_reg[0]  <= merge(lim_reg[0], w_data, w_strb);
            RTC_OFS_LIML[6:2]:    lim_reg[1]  <= merge(lim_reg[1], w_data, w_strb);
            RTC_OFS_LIMH[6:2]:    lim_reg[2]  <= merge(lim_reg[2], w_data, w_strb);
            RTC_OFS_LIMHH[6:2]:   lim_reg[3]  <= merge(lim_reg[3], w_data, w_strb);
            RTC_OFS_DBAND[6:2]:   dband_reg   <= merge(dband_reg, w_data, w_strb);
            RTC_OFS_LATCH[6:2]:   latch_reg   <= w_strb[0] ? w_data[3:0] : latch_reg;
            RTC_OFS_CHSEL[6:2]:   chsel_reg   <= w_strb[0] ? w_data[2:0] : chsel_reg;
            default:              latch_reg   <= latch_reg;
         endcase
      end
   end

   // one controller update = one write to the release register
   assign upd_pulse = do_write && aw_addr[6:2] == RTC_OFS_RELEASE[6:2];

   // previous release image, compared once per update so a held 1 never fires twice
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         release_prev_reg <= 32'h0000_0000;
      else if (upd_pulse)
         release_prev_reg <= release_reg;
   end
   // edge acts one cycle after the update, when release_reg holds the new image
   logic upd_d;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         upd_d <= 1'b0;
      else
         upd_d <= upd_pulse;
   end
   assign release_edge = upd_d ? (release_reg & ~release_prev_reg) : 32'h0000_0000;

   // read channel
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case ({1'b0, s_axi_araddr[6:2]})
         {1'b0, RTC_OFS_ENABLE[6:2]}:  rd_mux = enable_reg;
         {1'b0, RTC_OFS_RELEASE[6:2]}: rd_mux = release_reg;
         {1'b0, RTC_OFS_LIMLL[6:2]}:   rd_mux = lim_reg[0];
         {1'b0, RTC_OFS_LIML[6:2]}:    rd_mux = lim_reg[1];
         {1'b0, RTC_OFS_LIMH[6:2]}:    rd_mux = lim_reg[2];
         {1'b0, RTC_OFS_LIMHH[6:2]}:   rd_mux = lim_reg[3];
         {1'b0, RTC_OFS_DBAND[6:2]}:   rd_mux = dband_reg;
         {1'b0, RTC_OFS_LATCH[6:2]}:   rd_mux = {28'h0000000, latch_reg};
         {1'b0, RTC_OFS_ALARM[6:2]}:   rd_mux = alarm_reg;
         {1'b0, RTC_OFS_CAL[6:2]}:     rd_mux = cal_flags;
         {1'b0, RTC_OFS_TS_LO[6:2]}:   rd_mux = stamp_reg[31:0];
         {1'b0, RTC_OFS_TS_HI[6:2]}:   rd_mux = stamp_reg[63:32];
         {1'b0, RTC_OFS_ROLL[6:2]}:    rd_mux = {16'h0000, wrapping_ms_stamp};
         {1'b0, RTC_OFS_CHSEL[6:2]}:   rd_mux = {29'h0000000, chsel_reg};
         {1'b0, RTC_OFS_DATA[6:2]}:    rd_mux = data_reg[chsel_reg];
         {1'b0, RTC_OFS_RATE[6:2]}:    rd_mux = rate_reg[chsel_reg];
         default:                      rd_mux = 32'h0000_0000;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RTC_RESP_OK;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= s_axi_araddr[6] ? RTC_RESP_SLV : RTC_RESP_OK;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // millisecond tick and wrapping stamp
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ms_cnt_reg        <= 32'h0000_0000;
         wrapping_ms_stamp <= 16'h0000;
      end
      else if (ms_cnt_reg == 32'(MS_CYC - 1))
      begin
         ms_cnt_reg        <= 32'h0000_0000;
         wrapping_ms_stamp <= (wrapping_ms_stamp == RTC_ROLL_MAX) ? 16'h0000
                              : wrapping_ms_stamp + 16'h0001;
      end
      else
         ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
   end

   // scan stamp: latched when every channel has delivered a sample since the last one
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         seen_reg  <= '0;
         stamp_reg <= 64'h0000_0000_0000_0000;
      end
      else if (sample_in.valid)
      begin
         if ((seen_reg | (8'h01 << sample_in.ch)) == 8'hFF)
         begin
            seen_reg  <= '0;
            stamp_reg <= sys_time;
         end
         else
            seen_reg <= seen_reg | (8'h01 << sample_in.ch);
      end
   end

   genvar c;
   generate
      for (c = 0; c < RTC_NCH; c++)
      begin : g_ch
         logic hit, cal_hit;
         logic signed [31:0] d;
         logic [3:0] trip, inband, alarm_nx;
         assign hit     = sample_in.valid && sample_in.ch == 3'(c);
         assign cal_hit = cal_in.ch == 3'(c);
         assign d       = sample_in.value;

         // data and rate; the product truncates to 32 bits, fine for sane ranges
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               data_reg[c] <= 32'sh0000_0000;
               rate_reg[c] <= 32'sh0000_0000;
            end
            else if (hit)
            begin
               data_reg[c] <= d;
               rate_reg[c] <= 32'((d - data_reg[c]) * SAMPLE_HZ);
            end
         end

         // calibration state and flags
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               cal_st_reg[c]         <= RTC_ST_IDLE;
               good_high_ref_flag[c] <= 1'b0;
               bad_high_ref_flag[c]  <= 1'b0;
               cal_done_ok_flag[c]   <= 1'b0;
               cal_fault_flag[c]     <= 1'b1;     // uncalibrated after reset
               ok_cnt_reg[c]         <= 10'h000;
            end
            else
            begin
               case (cal_st_reg[c])
                  RTC_ST_IDLE, RTC_ST_HOLD:
                  begin
                     if (cal_hit && cal_in.hi_sampled)
                     begin
                        cal_st_reg[c]       <= RTC_ST_CAL;
                        cal_done_ok_flag[c] <= 1'b0;
                     end
                     else if (cal_st_reg[c] == RTC_ST_HOLD && hit)
                     begin
                        if (ok_cnt_reg[c] == 10'(RTC_OK_SAMPLES - 1))
                        begin
                           cal_done_ok_flag[c] <= 1'b0;
                           cal_st_reg[c]       <= RTC_ST_IDLE;
                        end
                        ok_cnt_reg[c] <= ok_cnt_reg[c] + 10'h001;
                     end
                  end
                  RTC_ST_CAL:
                  begin
                     if (cal_hit && cal_in.abort)
                     begin
                        cal_st_reg[c] <= RTC_ST_IDLE;
                        if (bad_high_ref_flag[c])
                           cal_fault_flag[c] <= 1'b1;
                     end
                     else if (cal_hit && cal_in.done && good_high_ref_flag[c])
                     begin
                        cal_st_reg[c]       <= RTC_ST_HOLD;
                        cal_done_ok_flag[c] <= 1'b1;
                        cal_fault_flag[c]   <= 1'b0;
                        ok_cnt_reg[c]       <= 10'h000;
                     end
                     else if (cal_hit && cal_in.done)
                     begin
                        cal_st_reg[c]     <= RTC_ST_IDLE;
                        cal_fault_flag[c] <= 1'b1;
                     end
                  end
                  default: cal_st_reg[c] <= RTC_ST_IDLE;
               endcase
               // reference sample result, valid and invalid exclusive
               if (cal_hit && cal_in.hi_sampled)
               begin
                  good_high_ref_flag[c] <= cal_in.hi_valid;
                  bad_high_ref_flag[c]  <= !cal_in.hi_valid;
               end
            end
         end

         // process alarms
         assign trip[RTC_B_LL] = data_reg[c] < lim_reg[0];
         assign trip[RTC_B_L]  = data_reg[c] < lim_reg[1];
         assign trip[RTC_B_H]  = data_reg[c] > lim_reg[2];
         assign trip[RTC_B_HH] = data_reg[c] > lim_reg[3];
         assign inband[RTC_B_LL] = data_reg[c] >= lim_reg[0] + $signed(dband_reg);
         assign inband[RTC_B_L]  = data_reg[c] >= lim_reg[1] + $signed(dband_reg);
         assign inband[RTC_B_H]  = data_reg[c] <= lim_reg[2] - $signed(dband_reg);
         assign inband[RTC_B_HH] = data_reg[c] <= lim_reg[3] - $signed(dband_reg);
         // a trip wins over a release in the same cycle
         always_comb
         begin
            alarm_nx = alarm_reg[4*c +: 4];
            for (int k = 0; k < 4; k++)
            begin
               if (!latch_reg[k] || inband[k] || release_edge[4*c+k])
                  alarm_nx[k] = 1'b0;
               if (trip[k])
                  alarm_nx[k] = 1'b1;
               if (!enable_reg[4*c+k])
                  alarm_nx[k] = 1'b0;
            end
         end
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               alarm_reg[4*c +: 4] <= 4'h0;
            else
               alarm_reg[4*c +: 4] <= alarm_nx;
         end
         assign cal_flags[4*c +: 4] = {cal_fault_flag[c], cal_done_ok_flag[c],
                                       bad_high_ref_flag[c], good_high_ref_flag[c]};
      end
   endgenerate
   assign alarm_flags = alarm_reg;

   // checks
   // an update whose previous image already held the ch0 low-low release bit
   sequence s_held_release;
      upd_pulse && release_reg[0];
   endsequence
   AST_REL_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
      s_held_release |=> !release_edge[0])
      else $error("held release fired again");
   AST_ROLL_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
      wrapping_ms_stamp == RTC_ROLL_MAX && ms_cnt_reg == 32'(MS_CYC - 1)
      |=> wrapping_ms_stamp == 16'h0000)
      else $error("ms stamp did not wrap");
   AST_EXCL: assert property (@(posedge aclk) disable iff (!aresetn)
      cal_in.hi_sampled && cal_in.ch == 3'h1
      |=> good_high_ref_flag[1] == $past(cal_in.hi_valid)
          && bad_high_ref_flag[1] == !$past(cal_in.hi_valid))
      else $error("reference flags wrong");
   AST_OK_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(cal_done_ok_flag[0]) |-> !cal_fault_flag[0])
      else $error("success with fault");
   AST_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
      cal_st_reg[1] == RTC_ST_CAL && cal_in.abort && cal_in.ch == 3'h1 && bad_high_ref_flag[1]
      |=> cal_fault_flag[1])
      else $error("abort did not set fault");
   AST_LL_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
      release_edge[RTC_B_LL] && !g_ch[0].trip[RTC_B_LL] |=> !alarm_reg[RTC_B_LL])
      else $error("low-low not released");
   AST_L_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
      release_edge[4+RTC_B_L] && !g_ch[1].trip[RTC_B_L] |=> !alarm_reg[4+RTC_B_L])
      else $error("low not released");
   AST_TRIP: assert property (@(posedge aclk) disable iff (!aresetn)
      g_ch[2].trip[RTC_B_H] && enable_reg[8+RTC_B_H] |=> alarm_reg[8+RTC_B_H])
      else $error("high alarm missed");
endmodule

//--- shared/rtc_pkg.sv
// package: register map, field layouts and constants of the rtd channel status block
package rtc_pkg;
   localparam int          RTC_NCH        = 8;
   localparam int          RTC_DW         = 32;
   // register byte offsets
   localparam logic [7:0] RTC_OFS_ENABLE = 8'h00;  // [4c+3:4c] en ll,l,h,hh for ch c
   localparam logic [7:0] RTC_OFS_RELEASE= 8'h04;  // [4c+3:4c] release ll,l,h,hh
   localparam logic [7:0] RTC_OFS_LIMLL  = 8'h08;
   localparam logic [7:0] RTC_OFS_LIML   = 8'h0C;
   localparam logic [7:0] RTC_OFS_LIMH   = 8'h10;
   localparam logic [7:0] RTC_OFS_LIMHH  = 8'h14;
   localparam logic [7:0] RTC_OFS_DBAND  = 8'h18;
   localparam logic [7:0] RTC_OFS_LATCH  = 8'h1C;  // [3:0] latch ll,l,h,hh
   localparam logic [7:0] RTC_OFS_ALARM  = 8'h20;  // [4c+3:4c] alarm flags
   localparam logic [7:0] RTC_OFS_CAL    = 8'h24;  // [4c+3:4c] good,bad,ok,fault
   localparam logic [7:0] RTC_OFS_TS_LO  = 8'h28;
   localparam logic [7:0] RTC_OFS_TS_HI  = 8'h2C;
   localparam logic [7:0] RTC_OFS_ROLL   = 8'h30;
   localparam logic [7:0] RTC_OFS_CHSEL  = 8'h34;  // channel index for data/rate view
   localparam logic [7:0] RTC_OFS_DATA   = 8'h38;
   localparam logic [7:0] RTC_OFS_RATE   = 8'h3C;
   // alarm field positions inside a channel nibble
   localparam int          RTC_B_LL       = 0;
   localparam int          RTC_B_L        = 1;
   localparam int          RTC_B_H        = 2;
   localparam int          RTC_B_HH       = 3;
   // timing
   localparam int          RTC_CLK_MHZ    = 125;
   localparam int          RTC_MS_US      = 1000;
   localparam int          RTC_MS_CYC     = RTC_CLK_MHZ * RTC_MS_US;
   localparam logic [15:0] RTC_ROLL_MAX   = 16'h7FFF;  // 32767 ms
   localparam int          RTC_OK_SAMPLES = 1000;
   localparam int          RTC_RATE_HZ    = 10;        // default sample rate
   localparam logic [1:0]  RTC_RESP_OK    = 2'h0;
   localparam logic [1:0]  RTC_RESP_SLV   = 2'h2;
   // one sample from the converter
   typedef struct packed {
      logic                 valid;
      logic [2:0]           ch;
      logic signed [31:0]   value;
   } rtc_sample_s;
   // calibration events from the calibration sequencer
   typedef struct packed {
      logic       hi_sampled;
      logic       hi_valid;
      logic       done;
      logic       abort;
      logic [2:0] ch;
   } rtc_cal_s;
   typedef enum logic [2:0] {
      RTC_ST_IDLE = 3'b001,
      RTC_ST_CAL  = 3'b010,
      RTC_ST_HOLD = 3'b100
   } rtc_cal_e;
endpackage

//--- test/rtc_ctrl_model.sv
// controller model: axi4-lite master that writes enables and releases and reads status
`timescale 1ns/1ps
module rtc_ctrl_model
   import rtc_pkg::*;
(
   input  wire logic        aclk,
   output logic [6:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [6:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   bit hang;
   // bus idle from time zero
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // one controller update; each item held until its own ready is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      bit ad;
      bit wd;
      n = 0;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      awaddr  <= a[6:0];
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(ad && wd) && n < 200)
      begin
         @(posedge aclk);
         ad = ad | awready;
         wd = wd | wready;
         if (ad) awvalid <= 1'b0;
         if (wd) wvalid <= 1'b0;
         n++;
      end
      // bvalid is registered, so it can only show at a later edge
      while (!bvalid && n < 200)
      begin
         @(posedge aclk);
         n++;
      end
      r = bresp;
      bready <= 1'b0;
      hang = n >= 200;
   endtask
   // status read; rready stays up until rvalid is sampled
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr  <= a[6:0];
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (!arready && n < 200);
      arvalid <= 1'b0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (!rvalid && n < 200);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      hang = n >= 200;
   endtask
endmodule

//--- test/rtd_channel_cal_status_alarm_ctrl_test.sv
// self-checking bench for the rtd channel status block against an integer model
`timescale 1ns/1ps
module rtd_channel_cal_status_alarm_ctrl_test;
   import rtc_pkg::*;
   logic        aclk = 0;
   logic        aresetn = 0;
   rtc_sample_s sample_in = '0;
   rtc_cal_s    cal_in = '0;
   logic [63:0] sys_time = '0;
   logic [6:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, alarm_flags, cal_flags, v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [63:0] t;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          cur[8] = '{default: 0};
   int          prv[8] = '{default: 0};
   int          lim[4] = '{-100, -50, 50, 100};
   always #4 aclk = ~aclk;
   // short ms tick so the rolling stamp wraps within the run
   rtc_status_ctrl #(.SAMPLE_HZ(RTC_RATE_HZ), .MS_CYC(2)) DUT (.aclk(aclk), .aresetn(aresetn),
      .sample_in(sample_in), .cal_in(cal_in), .sys_time(sys_time), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .alarm_flags(alarm_flags), .cal_flags(cal_flags));
   rtc_ctrl_model m (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // a hung bus counts as a mismatch and ends the run
   task automatic hung();
      if (m.hang)
      begin
         miscompares++;
         wrap_up();
      end
   endtask
   task automatic bw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      m.wr(a, d, r);
      hung();
      chk("bresp", er, r);
   endtask
   task automatic br(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      m.rd(a, v, r);
      hung();
      chk("rresp", er, r);
      chk("rdata", e, v);
   endtask
   // one converter sample; the model keeps current and previous value
   task automatic smp(input int c, input int x);
      @(posedge aclk);
      sample_in <= '{1'b1, c[2:0], x};
      prv[c] = cur[c];
      cur[c] = x;
      @(posedge aclk);
      sample_in.valid <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   // ev is hi_sampled, hi_valid, done, abort
   task automatic cal(input logic [3:0] ev, input int c);
      @(posedge aclk);
      cal_in <= {ev, c[2:0]};
      @(posedge aclk);
      cal_in <= '0;
      repeat (3) @(posedge aclk);
   endtask
   // kind k sits on channel k; d is the distance past the limit
   task automatic alm(input int d, input logic [31:0] e);
      for (int k = 0; k < 4; k++)
         smp(k, lim[k] + (k < 2 ? -d : d));
      chk("alarm_flags", e, alarm_flags);
   endtask
   // release lands one cycle after the write edge
   task automatic rel(input logic [31:0] x, input logic [31:0] e);
      bw(RTC_OFS_RELEASE, x, RTC_RESP_OK);
      repeat (4) @(posedge aclk);
      chk("alarm_flags", e, alarm_flags);
   endtask
   initial
   begin
      void'($urandom(32'h8fac2844));
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("cal_flags", 32'h88888888, cal_flags);
      $display("test reset done");
      cal(4'hC, 0);
      chk("good_high_ref_flag", 1'b1, cal_flags[0]);
      cal(4'h2, 0);
      chk("ch0 cal", 4'h5, cal_flags[3:0]);
      // calibrate ch1 first so the abort below has a cleared fault to set
      cal(4'hC, 1);
      cal(4'h2, 1);
      chk("ch1 cal", 4'h5, cal_flags[7:4]);
      cal(4'h8, 1);
      chk("ch1 cal", 4'h2, cal_flags[7:4]);
      cal(4'h1, 1);
      chk("ch1 cal", 4'hA, cal_flags[7:4]);
      cal(4'hC, 1);
      cal(4'h2, 1);
      chk("ch1 cal", 4'h5, cal_flags[7:4]);
      repeat (999) smp(0, 0);
      chk("cal_done_ok_flag", 1'b1, cal_flags[2]);
      smp(0, 0);
      chk("cal_done_ok_flag", 1'b0, cal_flags[2]);
      $display("test calibration done");
      bw(RTC_OFS_CHSEL, 32'h2, RTC_RESP_OK);
      for (int i = 0; i < 3; i++)
      begin
         smp(2, int'($urandom_range(2000)) - 1000);
         br(RTC_OFS_DATA, cur[2], RTC_RESP_OK);
         br(RTC_OFS_RATE, (cur[2] - prv[2]) * RTC_RATE_HZ, RTC_RESP_OK);
      end
      t = {$urandom, $urandom};
      sys_time <= t;
      for (int c = 0; c < 8; c++)
         smp(c, 0);
      sys_time <= ~t;
      br(RTC_OFS_TS_LO, t[31:0], RTC_RESP_OK);
      br(RTC_OFS_TS_HI, t[63:32], RTC_RESP_OK);
      br(8'h40, 32'h0, RTC_RESP_SLV);
      bw(RTC_OFS_ALARM, 32'h0, RTC_RESP_SLV);
      $display("test data and stamp done");
      for (int k = 0; k < 4; k++)
         bw(RTC_OFS_LIMLL + 8'(4 * k), lim[k], RTC_RESP_OK);
      bw(RTC_OFS_DBAND, 32'd10, RTC_RESP_OK);
      bw(RTC_OFS_LATCH, 32'hF, RTC_RESP_OK);
      bw(RTC_OFS_ENABLE, 32'h8421, RTC_RESP_OK);
      alm(100, 32'h8421);
      br(RTC_OFS_ALARM, 32'h8421, RTC_RESP_OK);
      alm(-5, 32'h8421);
      rel(32'h8421, 32'h0);
      alm(100, 32'h8421);
      alm(-5, 32'h8421);
      rel(32'h8421, 32'h8421);
      rel(32'h0, 32'h8421);
      rel(32'h8421, 32'h0);
      alm(100, 32'h8421);
      alm(-50, 32'h0);
      bw(RTC_OFS_ENABLE, 32'h0, RTC_RESP_OK);
      alm(100, 32'h0);
      // unlatched alarms follow the condition and drop without a release
      bw(RTC_OFS_LATCH, 32'h0, RTC_RESP_OK);
      bw(RTC_OFS_ENABLE, 32'h8421, RTC_RESP_OK);
      alm(100, 32'h8421);
      alm(-5, 32'h0);
      $display("test alarms done");
      // each read takes three edges, so the gap below is twice the step count less those three
      m.rd(RTC_OFS_ROLL, v, r);
      hung();
      chk("roll range", 1'b0, v[31:15]);
      repeat (2 * (32768 - int'(v[14:0]) + 5) - 3) @(posedge aclk);
      br(RTC_OFS_ROLL, 32'd5, RTC_RESP_OK);
      $display("test rolling stamp done");
      wrap_up();
   end
endmodule
